// ### hw/reconfig_message_handler.sv
// Downstream handler of reconfiguration control messages.
// Assumes framed character streams and a lookup that answers in one cycle.
module reconfig_message_handler (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// Received characters
	input  wire logic         rx_valid,
	input  wire logic [7:0]   rx_char,
	input  wire logic         rx_last,
	output logic              rx_ready,
	// Transmitted characters
	output logic              tx_valid,
	output logic [7:0]        tx_char,
	output logic              tx_last,
	input  wire logic         tx_ready,
	// Request check by the configuration store
	output logic              chk_valid,
	output logic [127:0]      chk_name,
	output logic [4:0]        chk_name_len,
	output logic [63:0]       chk_utc,
	output logic [47:0]       chk_dfct,
	input  wire logic         name_known,
	input  wire logic         inst_ok,
	input  wire logic         res_ok,
	input  wire logic         cancel_late,
	// Local definition
	input  wire logic         loc_def,
	input  wire logic [127:0] loc_name,
	input  wire logic [4:0]   loc_name_len,
	input  wire logic [63:0]  loc_utc,
	input  wire logic [47:0]  loc_dfct,
	output logic              loc_ready,
	// Pending reconfiguration
	input  wire logic         reconf_done,
	output logic              pending,
	output logic [127:0]      pend_name,
	output logic [4:0]        pend_name_len,
	output logic [63:0]       pend_utc,
	output logic [47:0]       pend_dfct
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	rcfg_pkg::state_t state, next_state;   // Receive, decide or send.
	rcfg_pkg::kind_t  kind, next_kind;     // Kind of reply in flight.
	logic [2:0]       fld, next_fld;       // Field being received.
	logic [4:0]       lens [5];            // Saturating length per field.
	logic [4:0]       next_lens [5];
	logic [55:0]      cmd, next_cmd;       // Last command characters.
	logic [23:0]      ext, next_ext;       // Last extension characters.
	logic [127:0]     nm, next_nm;         // Received name, first char high.
	logic [63:0]      utc, next_utc;       // Received UTC.
	logic [47:0]      dfct, next_dfct;     // Received frame count.
	logic [31:0]      cause, next_cause;   // Cause of an error reply.
	logic [5:0]       pos, next_pos;       // Position of tx_char.
	logic             next_tx_valid;
	logic [7:0]       next_tx_char;
	logic             next_tx_last;
	logic             next_pending;
	logic [127:0]     next_pend_name;
	logic [4:0]       next_pend_name_len;
	logic [63:0]      next_pend_utc;
	logic [47:0]      next_pend_dfct;
	logic             cmd_ok, name_ok, utc_ok, dfct_ok, take_loc;

	// ----------------------------------------
	// Decimal helpers
	// ----------------------------------------
	// A non-digit yields BAD_NUM, above every limit, so it always fails.
	function automatic logic [9:0] dig(input logic [7:0] c);
		if (c < rcfg_pkg::CH_ZERO || c > rcfg_pkg::CH_NINE) begin
			return rcfg_pkg::BAD_NUM;
		end
		return {2'b00, c - rcfg_pkg::CH_ZERO};
	endfunction

	function automatic logic [9:0] num2(input logic [7:0] a, input logic [7:0] b);
		if (dig(a) == rcfg_pkg::BAD_NUM || dig(b) == rcfg_pkg::BAD_NUM) begin
			return rcfg_pkg::BAD_NUM;
		end
		return 10'(dig(a) * 10'h00A + dig(b));
	endfunction

	function automatic logic [9:0] num3(input logic [7:0] a, input logic [7:0] b,
			input logic [7:0] c);
		if (num2(a, b) == rcfg_pkg::BAD_NUM || dig(c) == rcfg_pkg::BAD_NUM) begin
			return rcfg_pkg::BAD_NUM;
		end
		return 10'(num2(a, b) * 10'h00A + dig(c));
	endfunction

	// ----------------------------------------
	// Reply character at a position
	// ----------------------------------------
	// Replies are built on the fly from stored values, so no message buffer.
	function automatic logic [7:0] char_at(input logic [5:0] q, input rcfg_pkg::kind_t k,
			input logic [31:0] cs, input logic [127:0] n, input logic [4:0] len,
			input logic [63:0] u, input logic [47:0] d);
		int r;
		int l;
		r = int'(q) - 12;
		l = int'(len);
		if (q < 6'h07) begin
			return rcfg_pkg::CMD_WORD[8*(6-int'(q)) +: 8];
		end
		if (q == 6'h07 || q == 6'h0B) begin
			return rcfg_pkg::CH_SEP;
		end
		if (q < 6'h0B) begin
			unique case (k)
				rcfg_pkg::K_DEF: return rcfg_pkg::EXT_DEF[8*(10-int'(q)) +: 8];
				rcfg_pkg::K_ACK: return rcfg_pkg::EXT_ACK[8*(10-int'(q)) +: 8];
				default:         return rcfg_pkg::EXT_ERR[8*(10-int'(q)) +: 8];
			endcase
		end
		if (k == rcfg_pkg::K_ERR) begin
			return cs[8*(15-int'(q)) +: 8];
		end
		// Name, UTC and frame count follow, each after one space.
		if (r < l) begin
			return n[8*(15-r) +: 8];
		end
		if (r == l || r == l + 9) begin
			return rcfg_pkg::CH_SEP;
		end
		if (r < l + 9) begin
			return u[8*(l+8-r) +: 8];
		end
		return d[8*(l+15-r) +: 8];
	endfunction

	// ----------------------------------------
	// Field checks on the received message
	// ----------------------------------------
	// The command word must be exact in length too, not only its tail.
	assign cmd_ok = lens[0] == rcfg_pkg::CMD_LEN && cmd == rcfg_pkg::CMD_WORD
		&& lens[1] == rcfg_pkg::EXT_LEN;
	// Reserved monitoring names are never accepted as a target.
	assign name_ok = lens[2] != 5'h00 && lens[2] <= rcfg_pkg::NAME_MAX
		&& !(lens[2] == 5'h07 && nm[127:72] == rcfg_pkg::RSV_CUR)
		&& !(lens[2] == 5'h04 && nm[127:96] == rcfg_pkg::RSV_NEXT);
	// The UTC value only picks the window; the frame count picks the frame.
	assign utc_ok = lens[3] == rcfg_pkg::UTC_LEN
		&& utc[47:40] == rcfg_pkg::CH_COLON && utc[23:16] == rcfg_pkg::CH_COLON
		&& num2(utc[63:56], utc[55:48]) <= rcfg_pkg::HH_MAX
		&& num2(utc[39:32], utc[31:24]) <= rcfg_pkg::MS_MAX
		&& num2(utc[15:8], utc[7:0]) <= rcfg_pkg::MS_MAX;
	assign dfct_ok = lens[4] == rcfg_pkg::DFCT_LEN && dfct[31:24] == rcfg_pkg::CH_COLON
		&& num2(dfct[47:40], dfct[39:32]) <= rcfg_pkg::UU_MAX
		&& num3(dfct[23:16], dfct[15:8], dfct[7:0]) <= rcfg_pkg::LLL_MAX;

	// ----------------------------------------
	// Handshakes and check outputs
	// ----------------------------------------
	// A local definition is only taken between messages and with nothing pending.
	assign loc_ready = state == rcfg_pkg::S_RX && !pending && fld == rcfg_pkg::FLD_CMD
		&& lens[0] == 5'h00;
	assign take_loc = loc_def && loc_ready;
	assign rx_ready = state == rcfg_pkg::S_RX && !take_loc;
	assign chk_valid = state == rcfg_pkg::S_DEC && cmd_ok && ext == rcfg_pkg::EXT_REQ
		&& !pending;
	assign chk_name = nm;
	assign chk_name_len = lens[2];
	assign chk_utc = utc;
	assign chk_dfct = dfct;

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb begin
		next_state = state;
		next_kind = kind;
		next_fld = fld;
		next_lens = lens;
		next_cmd = cmd;
		next_ext = ext;
		next_nm = nm;
		next_utc = utc;
		next_dfct = dfct;
		next_cause = cause;
		next_pos = pos;
		next_tx_valid = tx_valid;
		next_pending = pending;
		next_pend_name = pend_name;
		next_pend_name_len = pend_name_len;
		next_pend_utc = pend_utc;
		next_pend_dfct = pend_dfct;
		// The procedure took place; stored values stay for a reply in flight.
		if (reconf_done) begin
			next_pending = 1'b0;
		end
		unique case (state)
			rcfg_pkg::S_RX: begin
				if (take_loc) begin
					// Imposed definition; upstream cannot refuse it.
					next_pend_name = loc_name;
					next_pend_name_len = loc_name_len;
					next_pend_utc = loc_utc;
					next_pend_dfct = loc_dfct;
					next_pending = 1'b1;
					next_kind = rcfg_pkg::K_DEF;
					next_state = rcfg_pkg::S_TX;
					next_pos = 6'h00;
					next_tx_valid = 1'b1;
				end else if (rx_valid) begin
					if (rx_char == rcfg_pkg::CH_SEP) begin
						// Extra spaces past the last field are ignored, so they leave it intact.
						if (fld != rcfg_pkg::FLD_DFCT) begin
							next_fld = 3'(fld + 3'h1);
						end
					end else begin
						if (lens[fld] != 5'h1F) begin
							next_lens[fld] = 5'(lens[fld] + 5'h01);
						end
						unique case (fld)
							rcfg_pkg::FLD_CMD: next_cmd = {cmd[47:0], rx_char};
							rcfg_pkg::FLD_EXT: next_ext = {ext[15:0], rx_char};
							rcfg_pkg::FLD_NAME: begin
								if (lens[2] < rcfg_pkg::NAME_MAX) begin
									next_nm[8*(15-int'(lens[2])) +: 8] = rx_char;
								end
							end
							rcfg_pkg::FLD_UTC: next_utc = {utc[55:0], rx_char};
							default: next_dfct = {dfct[39:0], rx_char};
						endcase
					end
					if (rx_last) begin
						next_state = rcfg_pkg::S_DEC;
					end
				end
			end
			rcfg_pkg::S_DEC: begin
				// Clear the parser for the next message, then answer.
				next_state = rcfg_pkg::S_RX;
				next_fld = rcfg_pkg::FLD_CMD;
				next_lens = '{default: 5'h00};
				// A shorter next name would otherwise keep stale tail characters.
				next_nm = '0;
				next_kind = rcfg_pkg::K_ERR;
				if (cmd_ok && ext == rcfg_pkg::EXT_REQ) begin
					next_state = rcfg_pkg::S_TX;
					if (pending) begin
						next_cause = rcfg_pkg::CS_PEND;
					end else if (!name_ok || !name_known) begin
						next_cause = rcfg_pkg::CS_NAME;
					end else if (!utc_ok || !dfct_ok || !inst_ok) begin
						next_cause = rcfg_pkg::CS_INST;
					end else if (!res_ok) begin
						next_cause = rcfg_pkg::CS_NRES;
					end else begin
						next_kind = rcfg_pkg::K_DEF;
						next_pend_name = nm;
						next_pend_name_len = lens[2];
						next_pend_utc = utc;
						next_pend_dfct = dfct;
						next_pending = 1'b1;
					end
				end else if (cmd_ok && ext == rcfg_pkg::EXT_INF) begin
					next_state = rcfg_pkg::S_TX;
					if (pending) begin
						next_kind = rcfg_pkg::K_DEF;
					end else begin
						next_cause = rcfg_pkg::CS_NONE;
					end
				end else if (cmd_ok && ext == rcfg_pkg::EXT_CAN) begin
					next_state = rcfg_pkg::S_TX;
					if (!pending) begin
						next_cause = rcfg_pkg::CS_NONE;
					end else if (cancel_late) begin
						next_cause = rcfg_pkg::CS_LATE;
					end else begin
						// Cancelled and acknowledged in the same edge.
						next_kind = rcfg_pkg::K_ACK;
						next_pending = 1'b0;
					end
				end
				// Anything else, including our own message kinds, is dropped.
				next_pos = 6'h00;
				next_tx_valid = next_state == rcfg_pkg::S_TX;
			end
			rcfg_pkg::S_TX: begin
				if (tx_ready) begin
					if (tx_last) begin
						next_tx_valid = 1'b0;
						next_state = rcfg_pkg::S_RX;
					end else begin
						next_pos = 6'(pos + 6'h01);
					end
				end
			end
			default: begin
				next_state = rcfg_pkg::S_RX;
				next_tx_valid = 1'b0;
			end
		endcase
		// Output character follows the next position and next stored values.
		next_tx_char = char_at(next_pos, next_kind, next_cause, next_pend_name,
			next_pend_name_len, next_pend_utc, next_pend_dfct);
		unique case (next_kind)
			rcfg_pkg::K_ACK: next_tx_last = next_pos == rcfg_pkg::POS_ACK_LAST;
			rcfg_pkg::K_ERR: next_tx_last = next_pos == rcfg_pkg::POS_ERR_LAST;
			default: next_tx_last = next_pos == 6'(rcfg_pkg::POS_DEF_TAIL
				+ {1'b0, next_pend_name_len});
		endcase
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	// Reset leaves nothing pending and the transmitter silent.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state <= rcfg_pkg::S_RX;
			kind <= rcfg_pkg::K_ERR;
			fld <= rcfg_pkg::FLD_CMD;
			lens <= '{default: 5'h00};
			cmd <= '0;
			ext <= '0;
			nm <= '0;
			utc <= '0;
			dfct <= '0;
			cause <= '0;
			pos <= 6'h00;
			tx_valid <= 1'b0;
			tx_char <= 8'h00;
			tx_last <= 1'b0;
			pending <= 1'b0;
			pend_name <= '0;
			pend_name_len <= 5'h00;
			pend_utc <= '0;
			pend_dfct <= '0;
		end else begin
			state <= next_state;
			kind <= next_kind;
			fld <= next_fld;
			lens <= next_lens;
			cmd <= next_cmd;
			ext <= next_ext;
			nm <= next_nm;
			utc <= next_utc;
			dfct <= next_dfct;
			cause <= next_cause;
			pos <= next_pos;
			tx_valid <= next_tx_valid;
			tx_char <= next_tx_char;
			tx_last <= next_tx_last;
			pending <= next_pending;
			pend_name <= next_pend_name;
			pend_name_len <= next_pend_name_len;
			pend_utc <= next_pend_utc;
			pend_dfct <= next_pend_dfct;
		end
	end
endmodule

// ### shared/rcfg_pkg.sv
// Constants for the reconfiguration message handler.
// Assumes ASCII characters, one per transfer, fields split by spaces.
package rcfg_pkg;
	// ----------------------------------------
	// Field lengths in characters
	// ----------------------------------------
	localparam logic [4:0] NAME_MAX = 5'h10;
	localparam logic [4:0] UTC_LEN  = 5'h08;
	localparam logic [4:0] DFCT_LEN = 5'h06;
	localparam logic [4:0] CMD_LEN  = 5'h07;
	localparam logic [4:0] EXT_LEN  = 5'h03;
	// ----------------------------------------
	// Characters and words
	// ----------------------------------------
	localparam logic [7:0]  CH_SEP   = 8'h20;
	localparam logic [7:0]  CH_COLON = 8'h3A;
	localparam logic [7:0]  CH_ZERO  = 8'h30;
	localparam logic [7:0]  CH_NINE  = 8'h39;
	localparam logic [55:0] CMD_WORD = "RCONFIG";
	localparam logic [23:0] EXT_REQ  = "REQ";
	localparam logic [23:0] EXT_DEF  = "DEF";
	localparam logic [23:0] EXT_INF  = "INF";
	localparam logic [23:0] EXT_CAN  = "CAN";
	localparam logic [23:0] EXT_ACK  = "ACK";
	localparam logic [23:0] EXT_ERR  = "ERR";
	localparam logic [31:0] CS_NAME  = "NAME";
	localparam logic [31:0] CS_INST  = "INST";
	localparam logic [31:0] CS_PEND  = "PEND";
	localparam logic [31:0] CS_NRES  = "NRES";
	localparam logic [31:0] CS_NONE  = "NONE";
	localparam logic [31:0] CS_LATE  = "LATE";
	localparam logic [55:0] RSV_CUR  = "CURRENT";
	localparam logic [31:0] RSV_NEXT = "NEXT";
	// ----------------------------------------
	// Value limits of the time fields
	// ----------------------------------------
	localparam logic [9:0] HH_MAX  = 10'h017;
	localparam logic [9:0] MS_MAX  = 10'h03B;
	localparam logic [9:0] UU_MAX  = 10'h013;
	localparam logic [9:0] LLL_MAX = 10'h0F9;
	localparam logic [9:0] BAD_NUM = 10'h3FF;
	// ----------------------------------------
	// Field indexes and message positions
	// ----------------------------------------
	localparam logic [2:0] FLD_CMD  = 3'h0;
	localparam logic [2:0] FLD_EXT  = 3'h1;
	localparam logic [2:0] FLD_NAME = 3'h2;
	localparam logic [2:0] FLD_UTC  = 3'h3;
	localparam logic [2:0] FLD_DFCT = 3'h4;
	localparam logic [5:0] POS_ACK_LAST = 6'h0A;
	localparam logic [5:0] POS_ERR_LAST = 6'h0F;
	localparam logic [5:0] POS_DEF_TAIL = 6'h1B;
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [2:0] {S_RX = 3'b001, S_DEC = 3'b010, S_TX = 3'b100} state_t;
	typedef enum logic [2:0] {K_DEF = 3'b001, K_ACK = 3'b010, K_ERR = 3'b100} kind_t;
endpackage

// ### test/rcfg_sva.sv
// Checker for the reconfiguration message handler, bound to its top module.
// Assumes one clock domain with a synchronous active-low reset.
module rcfg_sva (
	// Clock and reset
	input wire logic         clk,
	input wire logic         rst_n,
	// Character streams
	input wire logic         rx_ready,
	input wire logic         tx_valid,
	input wire logic [7:0]   tx_char,
	input wire logic         tx_last,
	input wire logic         tx_ready,
	// Store check, local definition and pending state
	input wire logic         chk_valid,
	input wire logic         loc_def,
	input wire logic         loc_ready,
	input wire logic [127:0] loc_name,
	input wire logic         reconf_done,
	input wire logic         pending,
	input wire logic [127:0] pend_name
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// The reset check must run while reset is low, so it drops the default disable.
	a_reset_quiet: assert property (disable iff (1'b0) !rst_n |=> !tx_valid && !pending)
		else $error("outputs not quiet after reset");
	a_tx_hold: assert property (tx_valid && !tx_ready
		|=> tx_valid && $stable(tx_char) && $stable(tx_last))
		else $error("reply character changed before it was taken");
	a_chk_idle: assert property (chk_valid |-> !pending && !rx_ready && !tx_valid)
		else $error("store check raised while a definition is pending");
	a_def_sets: assert property ($rose(pending)
		|-> ##[0:1] ($rose(tx_valid) && tx_char == 8'h52))
		else $error("pending set without a definition being launched");
	// A clear not caused by execution or reset must come with the acknowledge launch.
	a_ack_clears: assert property ($fell(pending) && $past(rst_n) && !$past(reconf_done)
		|-> $rose(tx_valid) && tx_char == 8'h52)
		else $error("pending cleared without acknowledge launch");
	a_loc_gate: assert property (loc_ready |-> !pending && !tx_valid)
		else $error("local definition offered while busy or pending");
	a_loc_take: assert property (loc_def && loc_ready
		|=> pending && pend_name == $past(loc_name))
		else $error("local definition not stored as pending");
	a_reply_mute: assert property ($rose(tx_valid) |-> !rx_ready)
		else $error("receiver open while reply starts");
	c_ack: cover property ($fell(pending) && !$past(reconf_done));
	c_local: cover property (loc_def && loc_ready);
	c_check: cover property (chk_valid);
endmodule

bind reconfig_message_handler rcfg_sva u_sva (.clk, .rst_n, .rx_ready, .tx_valid, .tx_char,
	.tx_last, .tx_ready, .chk_valid, .loc_def, .loc_ready, .loc_name, .reconf_done, .pending,
	.pend_name);

// ### test/rcfg_upstream.sv
// Upstream entity model: sends request strings and collects replies.
// Assumes the bench calls send and recv in turn, never both at once.
module rcfg_upstream (
	// Clock
	input wire logic        clk,
	// Requests towards the handler
	output logic            rx_valid,
	output logic [7:0]      rx_char,
	output logic            rx_last,
	input wire logic        rx_ready,
	// Replies from the handler
	input wire logic        tx_valid,
	input wire logic [7:0]  tx_char,
	input wire logic        tx_last,
	output logic            tx_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// Drivers
	// ----------------------------------------
	initial begin
		rx_valid = 1'b0;
		rx_char = 8'h00;
		rx_last = 1'b0;
		tx_ready = 1'b0;
	end
	// Only this side sends REQ, INF and CAN; each character is held until taken.
	task automatic send(input string m);
		for (int i = 0; i < m.len(); i++) begin
			@(negedge clk);
			rx_valid = 1'b1;
			rx_char = m[i];
			rx_last = (i == m.len() - 1);
			#1;
			while (!rx_ready) begin
				@(negedge clk);
				#1;
			end
			@(posedge clk);
		end
		@(negedge clk);
		rx_valid = 1'b0;
		rx_last = 1'b0;
		// A released line shows no stale character.
		rx_char = ~rx_char;
	endtask
	// Collects one reply; slow mode stalls every other cycle.
	task automatic recv(output logic [351:0] r, input bit slow);
		r = '0;
		forever begin
			@(negedge clk);
			tx_ready = slow ? !tx_ready : 1'b1;
			#1;
			if (tx_valid && tx_ready) begin
				r = {r[343:0], tx_char};
				if (tx_last)
					break;
			end
		end
		@(negedge clk);
		tx_ready = 1'b0;
	endtask
endmodule

// ### test/tb.sv
// Self-checking bench for the reconfiguration message handler.
// Assumes the package, checker and upstream model are compiled first.
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; \
	$display("unexpected %s expected %0h seen %0h", nm, e, g); end end
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic         clk, rst_n, rx_valid, rx_last, rx_ready, tx_valid, tx_last, tx_ready;
	logic [7:0]   rx_char, tx_char;
	logic         chk_valid, name_known, inst_ok, res_ok, cancel_late, loc_def, loc_ready;
	logic         reconf_done, pending;
	logic [127:0] chk_name, loc_name, pend_name;
	logic [4:0]   chk_name_len, loc_name_len, pend_name_len;
	logic [63:0]  chk_utc, loc_utc, pend_utc;
	logic [47:0]  chk_dfct, loc_dfct, pend_dfct;
	logic [351:0] got;
	logic [127:0] seen_name;   // Store check values caught in the decide cycle.
	logic [4:0]   seen_len;
	logic [63:0]  seen_utc;
	logic [47:0]  seen_dfct;
	int           seen_chk;    // Number of decide cycles with a store check.
	int           errors, cmp_count, cycles;
	// ----------------------------------------
	// Instances, clock and timeout
	// ----------------------------------------
	reconfig_message_handler uut (.clk, .rst_n, .rx_valid, .rx_char, .rx_last, .rx_ready,
		.tx_valid, .tx_char, .tx_last, .tx_ready, .chk_valid, .chk_name, .chk_name_len, .chk_utc,
		.chk_dfct, .name_known, .inst_ok, .res_ok, .cancel_late, .loc_def, .loc_name,
		.loc_name_len, .loc_utc, .loc_dfct, .loc_ready, .reconf_done, .pending, .pend_name,
		.pend_name_len, .pend_utc, .pend_dfct);
	rcfg_upstream up (.clk, .rx_valid, .rx_char, .rx_last, .rx_ready, .tx_valid, .tx_char,
		.tx_last, .tx_ready);
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// A hung handshake is cut off well beyond the roughly one thousand cycles the run needs.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			tally_and_finish();
		end
	end
	// The store check stands for one cycle only, so it is caught while it stands.
	always @(negedge clk) begin
		if (chk_valid === 1'b1) begin
			seen_chk++;
			seen_name = chk_name;
			seen_len = chk_name_len;
			seen_utc = chk_utc;
			seen_dfct = chk_dfct;
		end
	end
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [351:0] fold(string s);
		fold = '0;
		foreach (s[i]) fold = {fold[343:0], s[i]};
	endfunction
	// Packs n characters, first one highest, zero padded.
	function automatic logic [127:0] lpk(string s, int n);
		lpk = '0;
		for (int i = 0; i < n; i++) lpk = {lpk[119:0], (i < s.len()) ? s[i] : 8'h00};
	endfunction
	task automatic xfer(input string m, input string e, input bit slow);
		up.send(m);
		up.recv(got, slow);
		`CHK("reply", fold(e), got)
	endtask
	task automatic rej(input string n, u, d, input logic k, io, ro, input string c);
		int n0;
		n0 = seen_chk;
		name_known = k;
		inst_ok = io;
		res_ok = ro;
		xfer({"RCONFIG REQ ", n, " ", u, " ", d}, {"RCONFIG ERR ", c}, 1'b0);
		`CHK("pending", 1'b0, pending)
		`CHK("chk_count", n0 + 1, seen_chk)
		`CHK("chk_name", lpk(n, 16), seen_name)
		`CHK("chk_name_len", 5'(n.len()), seen_len)
		`CHK("chk_utc", 64'(lpk(u, 8)), seen_utc)
		`CHK("chk_dfct", 48'(lpk(d, 6)), seen_dfct)
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_idle();
		`CHK("pending", 1'b0, pending)
		`CHK("tx_valid", 1'b0, tx_valid)
		xfer("RCONFIG INF", "RCONFIG ERR NONE", 1'b0);
		xfer("RCONFIG CAN", "RCONFIG ERR NONE", 1'b0);
	endtask
	task automatic t_reject();
		rej("CFGA", "12:00:00", "00:000", 1'b0, 1'b1, 1'b1, "NAME");
		rej("NEXT", "12:00:00", "00:000", 1'b1, 1'b1, 1'b1, "NAME");
		rej("CURRENT", "12:00:00", "00:000", 1'b1, 1'b1, 1'b1, "NAME");
		rej("CFGA", "24:00:00", "00:000", 1'b1, 1'b1, 1'b1, "INST");
		rej("CFGA", "23:60:00", "00:000", 1'b1, 1'b1, 1'b1, "INST");
		rej("CFGA", "23:00:60", "00:000", 1'b1, 1'b1, 1'b1, "INST");
		rej("CFGA", "12:00:00", "20:000", 1'b1, 1'b1, 1'b1, "INST");
		rej("CFGA", "12:00:00", "19:250", 1'b1, 1'b1, 1'b1, "INST");
		rej("CFGA", "12:00:00", "00:000", 1'b1, 1'b0, 1'b1, "INST");
		rej("CFGA", "12:00:00", "00:000", 1'b1, 1'b1, 1'b0, "NRES");
	endtask
	task automatic t_accept_cancel();
		rej("ABCDEFGHIJKLMNOPQ", "23:59:59", "19:249", 1'b1, 1'b1, 1'b1, "NAME");
		xfer("RCONFIG REQ CFGB 23:59:59 19:249", "RCONFIG DEF CFGB 23:59:59 19:249", 1'b1);
		`CHK("pending", 1'b1, pending)
		`CHK("pend_utc", 64'(lpk("23:59:59", 8)), pend_utc)
		`CHK("pend_dfct", 48'(lpk("19:249", 6)), pend_dfct)
		`CHK("pend_name_len", 5'h04, pend_name_len)
		xfer("RCONFIG REQ CFGC 00:00:00 00:000", "RCONFIG ERR PEND", 1'b0);
		xfer("RCONFIG INF", "RCONFIG DEF CFGB 23:59:59 19:249", 1'b0);
		cancel_late = 1'b1;
		xfer("RCONFIG CAN", "RCONFIG ERR LATE", 1'b0);
		`CHK("pending", 1'b1, pending)
		cancel_late = 1'b0;
		xfer("RCONFIG CAN", "RCONFIG ACK", 1'b1);
		`CHK("pending", 1'b0, pending)
	endtask
	task automatic t_foreign();
		up.send("CONFDEF INF CFGB");
		repeat (6) @(negedge clk) `CHK("tx_valid", 1'b0, tx_valid)
		up.send("RCONFIG DEF CFGB 12:00:00 00:000");
		repeat (6) @(negedge clk) `CHK("tx_valid", 1'b0, tx_valid)
		xfer("RCONFIG INF", "RCONFIG ERR NONE", 1'b0);
	endtask
	task automatic t_local();
		loc_name = lpk("LOCAL1", 16);
		loc_name_len = 5'h06;
		loc_utc = 64'(lpk("00:00:00", 8));
		loc_dfct = 48'(lpk("00:000", 6));
		@(negedge clk);
		`CHK("loc_ready", 1'b1, loc_ready)
		loc_def = 1'b1;
		@(negedge clk);
		loc_def = 1'b0;
		up.recv(got, 1'b1);
		`CHK("reply", fold("RCONFIG DEF LOCAL1 00:00:00 00:000"), got)
		`CHK("pend_name", lpk("LOCAL1", 16), pend_name)
		`CHK("loc_ready", 1'b0, loc_ready)
		reconf_done = 1'b1;
		@(negedge clk);
		reconf_done = 1'b0;
		`CHK("pending", 1'b0, pending)
		loc_def = 1'b1;
		@(negedge clk);
		loc_def = 1'b0;
		rst_n = 1'b0;
		@(negedge clk);
		rst_n = 1'b1;
		`CHK("pending", 1'b0, pending)
		`CHK("tx_valid", 1'b0, tx_valid)
		xfer("RCONFIG INF", "RCONFIG ERR NONE", 1'b0);
	endtask
	task automatic tally_and_finish();
		if (errors == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{rst_n, name_known, inst_ok, res_ok, cancel_late, loc_def, reconf_done} = '0;
		{loc_name, loc_name_len, loc_utc, loc_dfct} = '0;
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		t_idle();
		t_reject();
		t_accept_cancel();
		t_foreign();
		t_local();
		tally_and_finish();
	end
endmodule
